/* File: rtl/blink_code.v */
/*
 * Blink code generator: a burst of PULSES on/off flashes, then a dark
 * pause, repeated while enabled. Output is a flip-flop.
 * Assumes a synchronous active-high reset; counts are in clock cycles.
 */
module blink_code #(
    parameter PULSES = 3,
    parameter HALF_CYC = 50000000,
    parameter PAUSE_CYC = 250000000
) (
    input wire clk,
    input wire rst,
    input wire enable,
    output reg led_q
);
    reg [31:0] cnt_q;
    reg [7:0] pulse_q;
    reg pause_q;

    always @(posedge clk) begin
        if (rst || !enable) begin
            cnt_q <= 32'h0;
            pulse_q <= 8'h0;
            pause_q <= 1'b0;
            led_q <= 1'b0;
        end else if (pause_q) begin
            if (cnt_q >= PAUSE_CYC - 1) begin
                cnt_q <= 32'h0;
                pause_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end else if (cnt_q >= HALF_CYC - 1) begin
            cnt_q <= 32'h0;
            led_q <= ~led_q;
            // Falling edge closes a pulse; after the last one go dark
            if (led_q) begin
                if (pulse_q == PULSES - 1) begin
                    pulse_q <= 8'h0;
                    pause_q <= 1'b1;
                end else begin
                    pulse_q <= pulse_q + 8'h1;
                end
            end
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule // blink_code

/* File: rtl/rotary_cfg_defines.vh */
/*
 * Constants for the rotary switch protocol and address loader: switch
 * positions, protocol codes, network presets, holding register map,
 * Modbus function and exception codes, indicator timing.
 * Assumes a 250 MHz system clock and inclusion by bare name.
 */
`ifndef ROTARY_CFG_DEFINES_VH
`define ROTARY_CFG_DEFINES_VH

// ----------------------------------------------------------------
// Clock and indicator timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define BLINK_HALF_NS 200000000
`define BLINK_PAUSE_NS 1000000000
`define FAULT_BLINKS 3

// ----------------------------------------------------------------
// Switch positions
// ----------------------------------------------------------------
`define DIGIT_MAX 4'h9
`define HUND_EIP_MAX 4'h2
`define HUND_PN 4'h3
`define HUND_EC 4'h4
`define HUND_MB 4'h5
`define HUND_CC 4'h6
`define SET_FACTORY 10'h3D3
`define SET_MB_AUTO 10'h1F4

// ----------------------------------------------------------------
// Protocol codes
// ----------------------------------------------------------------
`define PROTO_NONE 3'h0
`define PROTO_EIP 3'h1
`define PROTO_PN 3'h2
`define PROTO_EC 3'h3
`define PROTO_MB 3'h4
`define PROTO_CC 3'h5
`define PROTO_FACT 3'h6

// ----------------------------------------------------------------
// Network parameter source and request
// ----------------------------------------------------------------
`define SRC_STATIC 2'h0
`define SRC_AUTO 2'h1
`define SRC_SAVED 2'h2
`define SRC_NONE 2'h3
`define REQ_NONE 2'h0
`define REQ_DHCP 2'h1
`define REQ_BOOTP 2'h2
`define IP_PRESET 32'hC0A80100
`define IP_ZERO 32'h00000000
`define OCTET_MAX 9'h0FF

// ----------------------------------------------------------------
// Holding registers and Modbus codes
// ----------------------------------------------------------------
`define REG_LATCH 20'h61C80
`define REG_CFG_LAST 20'h61CD8
`define LATCH_RESET 16'h0000
`define FC_READ 8'h03
`define FC_WRITE1 8'h06
`define FC_WRITEN 8'h10
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_FAIL 8'h04
`define SOCK_MIN 4
`define SOCK_MAX 8

`endif

/* File: rtl/rotary_switch_protocol_config.v */
/*
 * Rotary switch protocol and address loader with the configuration
 * latch holding register, socket admission and status indicators.
 * Assumes switch, bus and memory inputs synchronous to SYS_CLK, an
 * external non-volatile store answering NV_ERASE_DONE, and a network
 * stack reporting NET_FAIL when a DHCP request round fails.
 */
`include "rotary_cfg_defines.vh"

module rotary_switch_protocol_config #(
    parameter MAX_SOCKETS = `SOCK_MAX,
    parameter BLINK_HALF_CYC = `BLINK_HALF_NS / `CLK_PERIOD_NS,
    parameter BLINK_PAUSE_CYC = `BLINK_PAUSE_NS / `CLK_PERIOD_NS
) (
    input wire SYS_CLK,
    input wire RESET,
    input wire [3:0] HUNDREDS_SELECTOR,
    input wire [3:0] TENS_SELECTOR,
    input wire [3:0] UNITS_SELECTOR,
    input wire RESTART_CMD,
    input wire CYCLIC_START,
    input wire NV_PROTO_VALID,
    input wire [2:0] NV_PROTO,
    input wire SAVED_VALID,
    input wire [31:0] SAVED_IP,
    input wire NV_ERASE_DONE,
    input wire NET_FAIL,
    input wire US_OK,
    input wire SOCK_OPEN,
    input wire SOCK_CLOSE,
    input wire HREG_REQ,
    input wire [7:0] HREG_FC,
    input wire [19:0] HREG_ADDR,
    input wire [15:0] HREG_WDATA,
    output reg [2:0] PROTOCOL,
    output reg [31:0] IP_ADDR,
    output reg [1:0] NET_SRC,
    output reg [1:0] NET_REQ,
    output reg COMM_EN,
    output reg CONFIG_FAULT,
    output reg NV_PROTO_WR,
    output reg [2:0] NV_PROTO_DATA,
    output reg NV_ERASE,
    output reg BUS_FAULT_INDICATOR,
    output reg US_LED_RED,
    output reg US_LED_GREEN,
    output reg SOCK_GRANT,
    output reg SOCK_REFUSE,
    output reg [3:0] SOCK_COUNT,
    output reg HREG_ACK,
    output reg [7:0] HREG_EXC,
    output reg [15:0] HREG_RDATA,
    output reg CFG_WR_OK,
    output reg CFG_OPEN,
    output reg CFG_APPLY
);
    // ----------------------------------------------------------------
    // States and helpers
    // ----------------------------------------------------------------
    localparam ST_SAMPLE = 5'b00001;
    localparam ST_DECIDE = 5'b00010;
    localparam ST_RUN = 5'b00100;
    localparam ST_FACTORY = 5'b01000;
    localparam ST_FAULT = 5'b10000;

    function [9:0] dec3;
        input [3:0] h;
        input [3:0] t;
        input [3:0] u;
        begin
            dec3 = h * 10'd100 + t * 10'd10 + {6'h0, u};
        end
    endfunction

    // Replace the two low decimal digits of an octet, keeping its hundreds if the result fits in 255
    function [7:0] repl2;
        input [7:0] base;
        input [6:0] two;
        reg [8:0] sum;
        begin
            sum = (base / 8'd100) * 9'd100 + {2'h0, two};
            repl2 = (sum > `OCTET_MAX) ? {1'b0, two} : sum[7:0];
        end
    endfunction

    reg [4:0] state_q;
    reg [3:0] h_q;
    reg [3:0] t_q;
    reg [3:0] u_q;
    reg stored_q;
    reg erasing_q;
    reg [15:0] latch_q;

    // ----------------------------------------------------------------
    // Decision from the sampled switches
    // ----------------------------------------------------------------
    wire [9:0] setting = dec3(h_q, t_q, u_q);
    wire [6:0] two = t_q * 7'd10 + {3'h0, u_q};
    wire digits_ok = (h_q <= `DIGIT_MAX) && (t_q <= `DIGIT_MAX) && (u_q <= `DIGIT_MAX);
    reg [2:0] sw_proto;
    reg [2:0] sel_proto;
    reg [31:0] ip_d;
    reg [1:0] src_d;
    reg ok_d;

    always @* begin
        case (h_q)
            `HUND_PN: sw_proto = `PROTO_PN;
            `HUND_EC: sw_proto = `PROTO_EC;
            `HUND_MB: sw_proto = `PROTO_MB;
            `HUND_CC: sw_proto = `PROTO_CC;
            default: sw_proto = (h_q <= `HUND_EIP_MAX) ? `PROTO_EIP : `PROTO_NONE;
        endcase
        // Stored protocol wins over the switch once committed
        sel_proto = NV_PROTO_VALID ? NV_PROTO : sw_proto;
        ip_d = `IP_ZERO;
        src_d = `SRC_NONE;
        ok_d = digits_ok && (sel_proto != `PROTO_NONE);
        case (sel_proto)
            `PROTO_MB: begin
                if (t_q == 4'h0 && u_q == 4'h0) begin
                    if (SAVED_VALID) begin
                        ip_d = SAVED_IP;
                        src_d = `SRC_SAVED;
                    end else begin
                        src_d = `SRC_AUTO;
                    end
                end else begin
                    // Only 1..99 can come from the switches here
                    ip_d = SAVED_VALID ? SAVED_IP : `IP_PRESET;
                    ip_d[7:0] = repl2(ip_d[7:0], two);
                    src_d = `SRC_STATIC;
                end
            end
            `PROTO_CC: begin
                ip_d = SAVED_VALID ? SAVED_IP : `IP_PRESET;
                ip_d[7:0] = repl2(ip_d[7:0], two);
                src_d = `SRC_STATIC;
            end
            `PROTO_EIP: begin
                ip_d = `IP_PRESET;
                ip_d[7:0] = setting[7:0];
                src_d = `SRC_STATIC;
                if (setting > {1'b0, `OCTET_MAX} || setting == 10'h0) begin
                    ok_d = 1'b0;
                end
            end
            default: src_d = `SRC_NONE;
        endcase
    end

    // ----------------------------------------------------------------
    // Startup sequencer
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            state_q <= ST_SAMPLE;
            h_q <= 4'h0;
            t_q <= 4'h0;
            u_q <= 4'h0;
            stored_q <= 1'b0;
            erasing_q <= 1'b0;
            PROTOCOL <= `PROTO_NONE;
            IP_ADDR <= `IP_ZERO;
            NET_SRC <= `SRC_NONE;
            NET_REQ <= `REQ_NONE;
            COMM_EN <= 1'b0;
            CONFIG_FAULT <= 1'b0;
            NV_PROTO_WR <= 1'b0;
            NV_PROTO_DATA <= `PROTO_NONE;
            NV_ERASE <= 1'b0;
        end else begin
            NV_PROTO_WR <= 1'b0;
            NV_ERASE <= 1'b0;
            case (state_q)
                ST_SAMPLE: begin
                    h_q <= HUNDREDS_SELECTOR;
                    t_q <= TENS_SELECTOR;
                    u_q <= UNITS_SELECTOR;
                    COMM_EN <= 1'b0;
                    CONFIG_FAULT <= 1'b0;
                    NET_REQ <= `REQ_NONE;
                    state_q <= ST_DECIDE;
                end
                ST_DECIDE: begin
                    stored_q <= NV_PROTO_VALID;
                    if (setting == `SET_FACTORY && digits_ok) begin
                        PROTOCOL <= `PROTO_FACT;
                        IP_ADDR <= `IP_ZERO;
                        NET_SRC <= `SRC_NONE;
                        NV_ERASE <= 1'b1;
                        erasing_q <= 1'b1;
                        state_q <= ST_FACTORY;
                    end else if (!ok_d) begin
                        PROTOCOL <= `PROTO_NONE;
                        CONFIG_FAULT <= 1'b1;
                        state_q <= ST_FAULT;
                    end else begin
                        // Address and source are frozen until the next restart
                        PROTOCOL <= sel_proto;
                        IP_ADDR <= ip_d;
                        NET_SRC <= src_d;
                        NET_REQ <= (src_d == `SRC_AUTO) ? `REQ_DHCP : `REQ_NONE;
                        COMM_EN <= 1'b1;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (RESTART_CMD) begin
                        state_q <= ST_SAMPLE;
                    end else begin
                        // Fallback only; the leased result is never saved here
                        if (NET_FAIL && NET_REQ == `REQ_DHCP) begin
                            NET_REQ <= `REQ_BOOTP;
                        end
                        if (CYCLIC_START && !stored_q) begin
                            stored_q <= 1'b1;
                            NV_PROTO_WR <= 1'b1;
                            NV_PROTO_DATA <= PROTOCOL;
                        end
                    end
                end
                ST_FACTORY: begin
                    // No exit but power; the operator must cycle it
                    COMM_EN <= 1'b0;
                    if (NV_ERASE_DONE) begin
                        erasing_q <= 1'b0;
                    end
                end
                ST_FAULT: begin
                    if (RESTART_CMD) begin
                        state_q <= ST_SAMPLE;
                    end
                end
                default: state_q <= ST_SAMPLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Socket admission
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            SOCK_COUNT <= 4'h0;
            SOCK_GRANT <= 1'b0;
            SOCK_REFUSE <= 1'b0;
        end else begin
            SOCK_GRANT <= 1'b0;
            SOCK_REFUSE <= 1'b0;
            if (!COMM_EN) begin
                SOCK_COUNT <= 4'h0;
                SOCK_REFUSE <= SOCK_OPEN;
            end else if (SOCK_OPEN && !SOCK_CLOSE) begin
                if (SOCK_COUNT < MAX_SOCKETS[3:0]) begin
                    SOCK_COUNT <= SOCK_COUNT + 4'h1;
                    SOCK_GRANT <= 1'b1;
                end else begin
                    SOCK_REFUSE <= 1'b1;
                end
            end else if (SOCK_OPEN && SOCK_CLOSE) begin
                SOCK_GRANT <= 1'b1;
            end else if (SOCK_CLOSE && SOCK_COUNT != 4'h0) begin
                SOCK_COUNT <= SOCK_COUNT - 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Holding register access and configuration latch
    // ----------------------------------------------------------------
    wire fc_write = (HREG_FC == `FC_WRITE1) || (HREG_FC == `FC_WRITEN);
    wire fc_ok = fc_write || (HREG_FC == `FC_READ);
    wire at_latch = (HREG_ADDR == `REG_LATCH);
    wire in_cfg = (HREG_ADDR > `REG_LATCH) && (HREG_ADDR <= `REG_CFG_LAST);
    wire new_bit = (HREG_WDATA != `LATCH_RESET);

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            latch_q <= `LATCH_RESET;
            HREG_ACK <= 1'b0;
            HREG_EXC <= `EXC_NONE;
            HREG_RDATA <= 16'h0000;
            CFG_WR_OK <= 1'b0;
            CFG_OPEN <= 1'b0;
            CFG_APPLY <= 1'b0;
        end else begin
            HREG_ACK <= HREG_REQ;
            CFG_WR_OK <= 1'b0;
            CFG_APPLY <= 1'b0;
            HREG_EXC <= `EXC_NONE;
            HREG_RDATA <= 16'h0000;
            if (HREG_REQ) begin
                if (!COMM_EN) begin
                    HREG_EXC <= `EXC_FAIL;
                end else if (!fc_ok) begin
                    HREG_EXC <= `EXC_FUNC;
                end else if (at_latch) begin
                    if (fc_write) begin
                        latch_q <= HREG_WDATA;
                        CFG_OPEN <= new_bit;
                        // Only the edges matter; rewriting the same value does nothing
                        if (new_bit && !CFG_OPEN) begin
                            CFG_OPEN <= 1'b1;
                        end
                        if (!new_bit && CFG_OPEN) begin
                            CFG_APPLY <= 1'b1;
                        end
                    end else begin
                        HREG_RDATA <= latch_q;
                    end
                end else if (in_cfg) begin
                    if (fc_write && !CFG_OPEN) begin
                        HREG_EXC <= `EXC_ADDR;
                    end else begin
                        CFG_WR_OK <= fc_write;
                    end
                end else begin
                    HREG_EXC <= `EXC_ADDR;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Indicators
    // ----------------------------------------------------------------
    wire bf_blink;
    wire us_blink;

    blink_code #(
        .PULSES(`FAULT_BLINKS),
        .HALF_CYC(BLINK_HALF_CYC),
        .PAUSE_CYC(BLINK_PAUSE_CYC)
    ) u_bf_blink (
        .clk(SYS_CLK),
        .rst(RESET),
        .enable(CONFIG_FAULT),
        .led_q(bf_blink)
    );

    // One pulse and a half-period pause: lit one half-period, dark two
    blink_code #(
        .PULSES(1),
        .HALF_CYC(BLINK_HALF_CYC),
        .PAUSE_CYC(BLINK_HALF_CYC)
    ) u_us_blink (
        .clk(SYS_CLK),
        .rst(RESET),
        .enable(erasing_q),
        .led_q(us_blink)
    );

    always @(posedge SYS_CLK) begin
        if (RESET) begin
            BUS_FAULT_INDICATOR <= 1'b0;
            US_LED_RED <= 1'b0;
            US_LED_GREEN <= 1'b0;
        end else begin
            BUS_FAULT_INDICATOR <= bf_blink;
            US_LED_RED <= erasing_q ? us_blink : !US_OK;
            US_LED_GREEN <= !erasing_q && US_OK;
        end
    end
endmodule // rotary_switch_protocol_config

/* File: verif/mb_client.sv */
/* Client model: turns one bench command into one holding register request.
   Assumes the bench raises go for a single cycle per request. */
module mb_client (
    input wire clk,
    input wire go,
    input wire [7:0] fc_i,
    input wire [19:0] addr_i,
    input wire [15:0] wd_i,
    output logic req,
    output logic [7:0] fc,
    output logic [19:0] addr,
    output logic [15:0] wd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req = 1'b0;
        fc = 8'h00;
        addr = 20'h00000;
        wd = 16'h0000;
    end
    // Released address and data lines drift so the device cannot lean on stale values; fc holds
    always @(posedge clk) begin
        req <= go;
        if (go) begin
            fc <= fc_i;
            addr <= addr_i;
            wd <= wd_i;
        end else begin
            addr <= ~addr;
            wd <= ~wd;
        end
    end
endmodule // mb_client

/* File: verif/rotary_switch_protocol_config_assertions.sv */
/* Checker for the switch loader: register answers, latch and sockets.
   Sees only the loader's ports; bound to it below the module. */
`include "rotary_cfg_defines.vh"
module cfg_checker #(
    parameter MAX_SOCKETS = 8
) (
    input wire SYS_CLK,
    input wire RESET,
    input wire SOCK_OPEN,
    input wire SOCK_CLOSE,
    input wire HREG_REQ,
    input wire [7:0] HREG_FC,
    input wire [19:0] HREG_ADDR,
    input wire [15:0] HREG_WDATA,
    input wire [2:0] PROTOCOL,
    input wire [31:0] IP_ADDR,
    input wire [1:0] NET_SRC,
    input wire COMM_EN,
    input wire SOCK_REFUSE,
    input wire [3:0] SOCK_COUNT,
    input wire HREG_ACK,
    input wire [7:0] HREG_EXC,
    input wire CFG_WR_OK,
    input wire CFG_OPEN,
    input wire CFG_APPLY
);
    wire go = HREG_REQ && COMM_EN;
    wire wr = HREG_FC == `FC_WRITE1 || HREG_FC == `FC_WRITEN;
    wire at_latch = HREG_ADDR == `REG_LATCH;
    // Channel and general registers sit just above the latch
    wire at_cfg = HREG_ADDR > `REG_LATCH && HREG_ADDR <= `REG_CFG_LAST;

    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    ack_follows_req_a: assert property (HREG_REQ |=> HREG_ACK)
        else $error("request left unanswered");
    bad_func_exc_a: assert property (go && !wr && HREG_FC != `FC_READ
        |=> HREG_EXC == `EXC_FUNC) else $error("unknown function not refused");
    offline_refusal_a: assert property (HREG_REQ && !COMM_EN
        |=> HREG_EXC == `EXC_FAIL) else $error("request served while offline");
    closed_write_block_a: assert property (go && wr && at_cfg && !CFG_OPEN
        |=> HREG_EXC == `EXC_ADDR && !CFG_WR_OK) else $error("closed write let through");
    open_write_pass_a: assert property (go && wr && at_cfg && CFG_OPEN
        |=> CFG_WR_OK && HREG_EXC == `EXC_NONE) else $error("open write refused");
    latch_opens_a: assert property (go && wr && at_latch && HREG_WDATA != 0 && !CFG_OPEN
        |=> $rose(CFG_OPEN)) else $error("latch did not open");
    latch_applies_a: assert property (go && wr && at_latch && HREG_WDATA == 0 && CFG_OPEN
        |=> CFG_APPLY && !CFG_OPEN) else $error("latch close did not apply");
    mb_octet_range_a: assert property (COMM_EN && PROTOCOL == `PROTO_MB
        && NET_SRC == `SRC_STATIC |-> IP_ADDR[31:8] == 24'hC0A801
        && IP_ADDR[7:0] inside {[8'h01:8'h63]}) else $error("switch address out of range");
    sock_full_refuse_a: assert property (SOCK_OPEN && !SOCK_CLOSE
        && SOCK_COUNT == MAX_SOCKETS |=> SOCK_REFUSE && SOCK_COUNT == MAX_SOCKETS)
        else $error("socket over limit accepted");

    cover property (go && wr && at_latch && HREG_WDATA == 0 && CFG_OPEN);
    cover property (go && wr && at_cfg && CFG_OPEN);
    cover property (SOCK_REFUSE);
endmodule // cfg_checker

bind rotary_switch_protocol_config cfg_checker #(.MAX_SOCKETS(MAX_SOCKETS)) chk (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .SOCK_OPEN(SOCK_OPEN), .SOCK_CLOSE(SOCK_CLOSE),
    .HREG_REQ(HREG_REQ), .HREG_FC(HREG_FC), .HREG_ADDR(HREG_ADDR),
    .HREG_WDATA(HREG_WDATA), .PROTOCOL(PROTOCOL), .IP_ADDR(IP_ADDR), .NET_SRC(NET_SRC),
    .COMM_EN(COMM_EN), .SOCK_REFUSE(SOCK_REFUSE), .SOCK_COUNT(SOCK_COUNT),
    .HREG_ACK(HREG_ACK), .HREG_EXC(HREG_EXC), .CFG_WR_OK(CFG_WR_OK),
    .CFG_OPEN(CFG_OPEN), .CFG_APPLY(CFG_APPLY)
);

/* File: verif/rotary_switch_protocol_config_bench.sv */
/* Bench for the switch loader: startup decode, restart, latch register,
   sockets, network source, fault and factory modes. Needs the client model. */
`include "rotary_cfg_defines.vh"
module rotary_switch_protocol_config_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic SYS_CLK, RESET, RESTART_CMD, CYCLIC_START, NV_PROTO_VALID, SAVED_VALID;
    logic NV_ERASE_DONE, NET_FAIL, US_OK, SOCK_OPEN, SOCK_CLOSE, HREG_REQ, go, b;
    logic [3:0] HUNDREDS_SELECTOR, TENS_SELECTOR, UNITS_SELECTOR, SOCK_COUNT, ev;
    logic [2:0] NV_PROTO, PROTOCOL, NV_PROTO_DATA;
    logic [31:0] SAVED_IP, IP_ADDR, ip;
    logic [1:0] NET_SRC, NET_REQ;
    logic COMM_EN, CONFIG_FAULT, NV_PROTO_WR, NV_ERASE, BUS_FAULT_INDICATOR;
    logic US_LED_RED, US_LED_GREEN, SOCK_GRANT, SOCK_REFUSE, HREG_ACK;
    logic CFG_WR_OK, CFG_OPEN, CFG_APPLY;
    logic [7:0] HREG_FC, HREG_EXC, f_i;
    logic [19:0] HREG_ADDR, a_i;
    logic [15:0] HREG_WDATA, HREG_RDATA, d_i;
    int miscompares, n_compared, latch, mcomm, n, k, t, u;

    rotary_switch_protocol_config #(.MAX_SOCKETS(4), .BLINK_HALF_CYC(4),
        .BLINK_PAUSE_CYC(8)) uut (.*);
    mb_client cli (.clk(SYS_CLK), .go(go), .fc_i(f_i), .addr_i(a_i), .wd_i(d_i),
        .req(HREG_REQ), .fc(HREG_FC), .addr(HREG_ADDR), .wd(HREG_WDATA));
    assign ev = {NV_PROTO_WR, SOCK_GRANT | SOCK_REFUSE, HREG_ACK, BUS_FAULT_INDICATOR};

    initial begin
        SYS_CLK = 1'b0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task final_report;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick;
        @(posedge SYS_CLK);
        #1;
    endtask

    task automatic await(input int s, input int lim);
        for (k = 0; k < lim && ev[s] !== 1'b1; k++)
            tick;
        if (ev[s] !== 1'b1) begin
            miscompares++;
            final_report;
        end
    endtask

    // A full power cycle: the only way out of factory mode
    task automatic boot(input [3:0] h, tn, un, input logic sv, nv);
        @(posedge SYS_CLK);
        RESET <= 1'b1;
        HUNDREDS_SELECTOR <= h;
        TENS_SELECTOR <= tn;
        UNITS_SELECTOR <= un;
        SAVED_VALID <= sv;
        NV_PROTO_VALID <= nv;
        repeat (8) @(posedge SYS_CLK);
        RESET <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        #1;
        latch = 0;
    endtask

    task automatic xfer(input [7:0] f, input [19:0] a, input [15:0] d);
        logic [7:0] ex;
        logic ap, ok, wr;
        wr = f == `FC_WRITE1 || f == `FC_WRITEN;
        ap = 1'b0;
        ok = 1'b0;
        ex = `EXC_NONE;
        if (!mcomm)
            ex = `EXC_FAIL;
        else if (!wr && f != `FC_READ)
            ex = `EXC_FUNC;
        else if (a == `REG_LATCH && wr) begin
            ap = latch != 0 && d == 0;
            latch = d;
        end else if (a > `REG_LATCH && a <= `REG_CFG_LAST) begin
            ok = wr && latch != 0;
            ex = (wr && !ok) ? `EXC_ADDR : `EXC_NONE;
        end else if (a != `REG_LATCH)
            ex = `EXC_ADDR;
        @(posedge SYS_CLK);
        go <= 1'b1;
        f_i <= f;
        a_i <= a;
        d_i <= d;
        @(posedge SYS_CLK);
        go <= 1'b0;
        #1;
        await(1, 4);
        chk(HREG_EXC, ex);
        if (f == `FC_READ && a == `REG_LATCH && mcomm) chk(HREG_RDATA, latch);
        chk({CFG_WR_OK, CFG_APPLY, CFG_OPEN}, {ok, ap, latch != 0});
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {RESTART_CMD, CYCLIC_START, NET_FAIL, SOCK_OPEN, SOCK_CLOSE, go} = 6'h00;
        {NV_ERASE_DONE, NV_PROTO_VALID, SAVED_VALID, f_i, a_i, d_i} = 47'h0;
        {HUNDREDS_SELECTOR, TENS_SELECTOR, UNITS_SELECTOR, SAVED_IP} = 44'h0;
        RESET = 1'b1;
        US_OK = 1'b1;
        NV_PROTO = `PROTO_MB;
        b = $urandom(81579);
        boot(5, 1, 0, 0, 0);
        mcomm = 1;
        ip = `IP_PRESET | 32'h0000000A;
        chk({PROTOCOL, COMM_EN}, {`PROTO_MB, 1'b1});
        chk(IP_ADDR, ip);
        for (int i = 0; i < 3; i++) begin
            t = $urandom % 10;
            u = $urandom % 10;
            if (t == 0 && u == 0) u = 1;
            @(posedge SYS_CLK);
            TENS_SELECTOR <= 4'(t);
            UNITS_SELECTOR <= 4'(u);
            repeat (4) tick;
            chk(IP_ADDR, ip);
            @(posedge SYS_CLK);
            RESTART_CMD <= 1'b1;
            @(posedge SYS_CLK);
            RESTART_CMD <= 1'b0;
            repeat (4) tick;
            ip = `IP_PRESET | 32'(t * 10 + u);
            chk(IP_ADDR, ip);
        end
        xfer(`FC_READ, `REG_LATCH, 16'h0000);
        xfer(`FC_WRITE1, `REG_CFG_LAST, 16'h0001);
        xfer(`FC_WRITE1, `REG_LATCH, 16'(1 + $urandom % 16'hFFFE));
        xfer(`FC_WRITEN, `REG_LATCH + 20'h00001, 16'h0005);
        xfer(`FC_READ, `REG_LATCH, 16'h0000);
        xfer(`FC_WRITEN, `REG_LATCH, 16'h0000);
        xfer(8'h05, `REG_LATCH, 16'h0001);
        xfer(`FC_READ, 20'h00000, 16'h0000);
        for (n = 0; n <= 4; n++) begin
            @(posedge SYS_CLK);
            SOCK_OPEN <= 1'b1;
            @(posedge SYS_CLK);
            SOCK_OPEN <= 1'b0;
            #1;
            await(2, 4);
            chk({SOCK_GRANT, SOCK_REFUSE}, {n < 4, n >= 4});
            tick;
            chk(SOCK_COUNT, (n < 4) ? n + 1 : 4);
        end
        @(posedge SYS_CLK);
        SOCK_CLOSE <= 1'b1;
        @(posedge SYS_CLK);
        SOCK_CLOSE <= 1'b0;
        repeat (2) tick;
        chk(SOCK_COUNT, 3);
        @(posedge SYS_CLK);
        CYCLIC_START <= 1'b1;
        @(posedge SYS_CLK);
        CYCLIC_START <= 1'b0;
        #1;
        await(3, 4);
        chk(NV_PROTO_DATA, `PROTO_MB);
        boot(3, 0, 7, 0, 1);
        chk(PROTOCOL, `PROTO_MB);
        boot(5, 0, 0, 0, 0);
        chk({NET_SRC, NET_REQ}, {`SRC_AUTO, `REQ_DHCP});
        @(posedge SYS_CLK);
        NET_FAIL <= 1'b1;
        @(posedge SYS_CLK);
        NET_FAIL <= 1'b0;
        repeat (2) tick;
        chk(NET_REQ, `REQ_BOOTP);
        @(posedge SYS_CLK) SAVED_IP <= $urandom;
        boot(5, 0, 0, 1, 0);
        chk(NET_SRC, `SRC_SAVED);
        chk(IP_ADDR, SAVED_IP);
        boot(2, 1, 2, 0, 0);
        chk(PROTOCOL, `PROTO_EIP);
        chk(IP_ADDR, `IP_PRESET | 32'h000000D4);
        boot(8, 0, 0, 0, 0);
        chk(CONFIG_FAULT, 1'b1);
        await(0, 40);
        // Window ends before the next burst starts
        n = 1;
        for (int i = 0; i < 27; i++) begin
            b = BUS_FAULT_INDICATOR;
            tick;
            if (!b && BUS_FAULT_INDICATOR) n++;
        end
        chk(n, 3);
        boot(9, 7, 9, 0, 0);
        mcomm = 0;
        chk({PROTOCOL, COMM_EN}, {`PROTO_FACT, 1'b0});
        xfer(`FC_READ, `REG_LATCH, 16'h0000);
        b = US_LED_RED;
        repeat (4) tick;
        chk(US_LED_RED, !b);
        @(posedge SYS_CLK);
        NV_ERASE_DONE <= 1'b1;
        repeat (3) tick;
        chk({US_LED_GREEN, US_LED_RED}, {US_OK, !US_OK});
        final_report;
    end

    initial begin
        #200000;
        miscompares++;
        final_report;
    end
endmodule // rotary_switch_protocol_config_bench
